//--- hw/pump_keypad_pkg.sv
// constants, types and register map of the pump keypad handler
// assumes a single 10 MHz clock and an APB master with 32-bit data
package pump_keypad_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ       = 10_000_000;
  localparam int DEBOUNCE_MS  = 20;
  localparam int LONG_MS      = 1000;
  localparam int REPEAT_MS    = 100;
  localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int LONG_CYC     = CLK_HZ / 1000 * LONG_MS;
  localparam int REPEAT_CYC   = CLK_HZ / 1000 * REPEAT_MS;
  localparam int CNT_W        = 24;

  // ****************************************
  // key inputs
  // ****************************************
  localparam int K_DIR   = 0;
  localparam int K_ENT   = 1;
  localparam int K_PLUS  = 2;
  localparam int K_MINUS = 3;
  localparam int K_RUN   = 4;
  localparam int K_FUNC  = 5;
  localparam int K_FAULT = 6;
  localparam int NIN     = 7;

  // ****************************************
  // control modes
  // ****************************************
  typedef logic [2:0] mode_t;
  localparam mode_t MODE_INT  = 3'h0;
  localparam mode_t MODE_EXT  = 3'h1;
  localparam mode_t MODE_COMM = 3'h2;
  localparam mode_t MODE_V5   = 3'h3;
  localparam mode_t MODE_V10  = 3'h4;
  localparam mode_t MODE_MA   = 3'h5;
  localparam mode_t MODE_KHZ  = 3'h6;

  // ****************************************
  // speed in tenths of rpm, parameters
  // ****************************************
  typedef logic [11:0] speed_t;
  localparam speed_t STEP_LO   = 12'h001;
  localparam speed_t STEP_HI   = 12'h00A;
  localparam speed_t MAX_LO    = 12'h3E8;
  localparam speed_t MAX_HI    = 12'hBB8;
  localparam speed_t SPEED_RST = 12'h000;
  localparam int     NPARAM    = 4;
  typedef logic [1:0] pidx_t;
  typedef logic [7:0] par_t;
  localparam pidx_t  PIDX_LAST = 2'h3;
  localparam par_t   PAR_RST   = 8'h00;

  // ****************************************
  // register map and fields
  // ****************************************
  typedef logic [7:0] addr_t;
  localparam addr_t OFF_CTRL    = 8'h00;
  localparam addr_t OFF_STATUS  = 8'h04;
  localparam addr_t OFF_SPEED   = 8'h08;
  localparam addr_t OFF_PARAMS  = 8'h0C;
  localparam addr_t OFF_INTSTAT = 8'h10;
  localparam addr_t OFF_INTMASK = 8'h14;
  localparam int CTRL_MODEL = 0;
  localparam int CTRL_LOCK  = 1;
  localparam int ST_RUN     = 0;
  localparam int ST_DIR     = 1;
  localparam int ST_FULL    = 2;
  localparam int ST_SET     = 3;
  localparam int ST_LOCK    = 4;
  localparam int ST_ALARM   = 5;
  localparam int ST_MODE    = 8;
  localparam int ST_PIDX    = 12;
  localparam int SPD_SET    = 16;
  localparam int IRQ_SAVE   = 0;
  localparam int IRQ_MODE   = 1;
  localparam int IRQ_ALARM  = 2;
  localparam int IRQ_FULL   = 3;
  localparam int IRQ_W      = 4;
  localparam logic [3:0] MASK_RST = 4'h0;

  typedef enum logic [1:0] {
    SCR_RUN = 2'b01,
    SCR_SET = 2'b10
  } screen_e;

  typedef struct packed {
    logic run;
    logic dir;
  } motor_s;
  localparam motor_s MOTOR_RST = '{run: 1'b0, dir: 1'b0};

endpackage

//--- hw/pump_keypad_handler.sv
// front-panel key handler of a peristaltic pump drive with APB registers
// assumes raw key and fault levels from pins, active high, asynchronous to mclk
// Operation
// - direction tap reverses flow only in keypad mode
// - enter tap on setting screen accepts value, moves to next parameter
// - enter tap on last parameter stores all, returns to run screen
// - enter hold on run screen, keypad/footswitch mode, runs at maximum speed
// - enter release after full speed restores previous run state and direction
// - plus/minus tap on run screen steps set speed up or down
// - plus/minus ignored on run screen in external or communication mode
// - plus/minus on setting screen step value, repeating while held
// - start/stop tap toggles pump in keypad mode
// - start/stop ignored in footswitch, external and communication modes
// - function long press opens the setting screen
// - function long press on setting screen selects next parameter
// - function long press unlocks a locked keypad
// - function long press clears a shown alarm
// - function key ignored while the pump runs
// - direction plus enter held, stopped, non-keypad mode forces keypad mode
// - function tap steps through the seven control modes
module pump_keypad_handler #(
  parameter int DEBOUNCE = pump_keypad_pkg::DEBOUNCE_CYC,
  parameter int LONG     = pump_keypad_pkg::LONG_CYC,
  parameter int REPEAT   = pump_keypad_pkg::REPEAT_CYC
) (
  // clock and reset
  input  wire logic                            mclk,
  input  wire logic                            sys_rst,
  // apb slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire pump_keypad_pkg::addr_t          paddr,
  input  wire logic [31:0]                     pwdata,
  output logic [31:0]                          prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // keys and fault pin
  input  wire logic [pump_keypad_pkg::NIN-1:0] keyRaw,
  // pump drive
  output logic                                 pumpRun,
  output logic                                 pumpDir,
  output pump_keypad_pkg::speed_t              pumpSpeed,
  // display
  output logic                                 fullInd,
  output pump_keypad_pkg::mode_t               ctrlMode,
  output logic                                 setScreen,
  output pump_keypad_pkg::pidx_t               paramIdx,
  // interrupt
  output logic                                 irq
);
  localparam int N = pump_keypad_pkg::NIN;
  localparam int W = pump_keypad_pkg::CNT_W;
  localparam logic [W-1:0] DB_MAX  = W'(DEBOUNCE - 1);
  localparam logic [W-1:0] LNG_MAX = W'(LONG - 1);
  localparam logic [W-1:0] REP_MAX = W'(REPEAT - 1);
  logic [N-1:0] lvl;
  logic [N-1:0] tapEv;
  logic [N-1:0] longEv;
  logic [N-1:0] repEv;
  logic [N-1:0] pressEv;
  // ****************************************
  // key filters
  // ****************************************
  for (genvar i = 0; i < N; i++)
  begin : g_key
    logic [2:0]   sync_q;
    logic         lvl_q;
    logic         prev_q;
    logic         long_q;
    logic [W-1:0] db_q;
    logic [W-1:0] hold_q;
    logic [W-1:0] rep_q;
    wire          agree = sync_q[2] == sync_q[1];
    always_ff @(posedge mclk)
    begin
      if (sys_rst)
      begin
        sync_q <= 3'h0;
        db_q   <= '0;
        lvl_q  <= 1'b0;
        prev_q <= 1'b0;
      end
      else
      begin
        sync_q <= {sync_q[1:0], keyRaw[i]};
        db_q   <= !agree ? '0 : (db_q == DB_MAX) ? db_q : db_q + 1'b1;
        if (agree && db_q == DB_MAX)
          lvl_q <= sync_q[2];
        prev_q <= lvl_q;
      end
    end
    // hold time decides tap or long press; repeat runs after a long press
    always_ff @(posedge mclk)
    begin
      if (sys_rst || !lvl_q)
      begin
        hold_q <= '0;
        rep_q  <= '0;
        long_q <= 1'b0;
      end
      else if (!long_q)
      begin
        hold_q <= hold_q + 1'b1;
        long_q <= hold_q == LNG_MAX;
      end
      else
        rep_q <= (rep_q == REP_MAX) ? '0 : rep_q + 1'b1;
    end
    assign lvl[i]     = lvl_q;
    assign tapEv[i]   = prev_q & ~lvl_q & ~long_q;
    assign longEv[i]  = lvl_q & ~long_q & (hold_q == LNG_MAX);
    assign repEv[i]   = lvl_q & long_q & (rep_q == REP_MAX);
    assign pressEv[i] = lvl_q & ~prev_q;
  end
  // ****************************************
  // state
  // ****************************************
  pump_keypad_pkg::mode_t   mode_q;
  pump_keypad_pkg::screen_e screen_q;
  pump_keypad_pkg::motor_s  motor_q;
  pump_keypad_pkg::motor_s  saved_q;
  pump_keypad_pkg::speed_t  spd_q;
  pump_keypad_pkg::pidx_t   idx_q;
  pump_keypad_pkg::par_t    edit_q  [pump_keypad_pkg::NPARAM];
  pump_keypad_pkg::par_t    store_q [pump_keypad_pkg::NPARAM];
  logic                     full_q;
  logic                     lock_q;
  logic                     alarm_q;
  logic                     model_q;
  logic                     combo_q;
  logic [3:0]               stat_q;
  logic [3:0]               mask_q;
  logic [31:0]              rdata_q;
  // ****************************************
  // key decode
  // ****************************************
  wire inInt   = mode_q == pump_keypad_pkg::MODE_INT;
  wire inExt   = mode_q == pump_keypad_pkg::MODE_EXT;
  wire runScr  = screen_q == pump_keypad_pkg::SCR_RUN;
  wire setScr  = screen_q == pump_keypad_pkg::SCR_SET;
  wire running = motor_q.run | full_q;
  wire free    = !lock_q && runScr && !full_q;
  // both halves of the reset combination are kept out of their own actions
  wire [N-1:0] tapG  = tapEv & ~({N{combo_q}} & N'(7'h03));
  wire comboLong     = (longEv[pump_keypad_pkg::K_ENT] & lvl[pump_keypad_pkg::K_DIR])
                     | (longEv[pump_keypad_pkg::K_DIR] & lvl[pump_keypad_pkg::K_ENT]);
  wire comboGo       = comboLong && !inInt && !running;
  wire dirTap  = tapG[pump_keypad_pkg::K_DIR] && free && inInt;
  wire runTap  = tapG[pump_keypad_pkg::K_RUN] && free && inInt;
  wire spdOk   = free && (inInt || inExt);
  wire spdInc  = tapG[pump_keypad_pkg::K_PLUS] && spdOk;
  wire spdDec  = tapG[pump_keypad_pkg::K_MINUS] && spdOk;
  wire editInc = (tapG[pump_keypad_pkg::K_PLUS] | repEv[pump_keypad_pkg::K_PLUS])
                 && setScr && !lock_q;
  wire editDec = (tapG[pump_keypad_pkg::K_MINUS] | repEv[pump_keypad_pkg::K_MINUS])
                 && setScr && !lock_q;
  wire entTap  = tapG[pump_keypad_pkg::K_ENT] && setScr && !lock_q;
  wire entLast = entTap && idx_q == pump_keypad_pkg::PIDX_LAST;
  wire fullGo  = longEv[pump_keypad_pkg::K_ENT] && !lvl[pump_keypad_pkg::K_DIR]
                 && free && (inInt || inExt);
  wire fullEnd = full_q && !lvl[pump_keypad_pkg::K_ENT];
  // function key acts only while stopped; unlock, then alarm, then screen
  wire funcLong = longEv[pump_keypad_pkg::K_FUNC] && !running;
  wire unlock   = funcLong && lock_q;
  wire clrAlarm = funcLong && !lock_q && alarm_q;
  wire nextPar  = funcLong && !lock_q && !alarm_q && setScr;
  wire openSet  = funcLong && !lock_q && !alarm_q && runScr;
  wire modeStep = tapG[pump_keypad_pkg::K_FUNC] && !running && !lock_q && runScr;
  wire faultEv  = pressEv[pump_keypad_pkg::K_FAULT];
  wire pump_keypad_pkg::speed_t stepV = model_q ? pump_keypad_pkg::STEP_HI
                                                : pump_keypad_pkg::STEP_LO;
  wire pump_keypad_pkg::speed_t maxV  = model_q ? pump_keypad_pkg::MAX_HI
                                                : pump_keypad_pkg::MAX_LO;
  wire pump_keypad_pkg::speed_t spdUp = (spd_q > maxV - stepV) ? maxV : spd_q + stepV;
  wire pump_keypad_pkg::speed_t spdDn = (spd_q < stepV) ? 12'h000 : spd_q - stepV;
  wire pump_keypad_pkg::mode_t  modeNx = (mode_q == pump_keypad_pkg::MODE_KHZ)
                                         ? pump_keypad_pkg::MODE_INT : mode_q + 3'h1;

  // ****************************************
  // apb decode
  // ****************************************
  wire setup    = psel && !penable;
  wire access   = psel && penable;
  wire hitCtrl  = paddr == pump_keypad_pkg::OFF_CTRL;
  wire hitStat  = paddr == pump_keypad_pkg::OFF_STATUS;
  wire hitSpd   = paddr == pump_keypad_pkg::OFF_SPEED;
  wire hitPar   = paddr == pump_keypad_pkg::OFF_PARAMS;
  wire hitInt   = paddr == pump_keypad_pkg::OFF_INTSTAT;
  wire hitMask  = paddr == pump_keypad_pkg::OFF_INTMASK;
  wire hit      = hitCtrl | hitStat | hitSpd | hitPar | hitInt | hitMask;
  wire wrCtrl   = access && pwrite && hitCtrl;
  wire wrInt    = access && pwrite && hitInt;
  wire wrMask   = access && pwrite && hitMask;
  wire lockSet  = wrCtrl && pwdata[pump_keypad_pkg::CTRL_LOCK];
  wire [3:0] evVec = {fullGo, faultEv, modeStep | comboGo, entLast};
  logic [31:0] stWord;
  logic [31:0] rdMux;
  always_comb
  begin
    stWord = 32'h0000_0000;
    stWord[pump_keypad_pkg::ST_RUN]   = motor_q.run;
    stWord[pump_keypad_pkg::ST_DIR]   = motor_q.dir;
    stWord[pump_keypad_pkg::ST_FULL]  = full_q;
    stWord[pump_keypad_pkg::ST_SET]   = setScr;
    stWord[pump_keypad_pkg::ST_LOCK]  = lock_q;
    stWord[pump_keypad_pkg::ST_ALARM] = alarm_q;
    stWord[pump_keypad_pkg::ST_MODE +: 3] = mode_q;
    stWord[pump_keypad_pkg::ST_PIDX +: 2] = idx_q;
  end
  assign rdMux = hitCtrl ? {30'h0, lock_q, model_q}
               : hitStat ? stWord
               : hitSpd  ? {4'h0, spd_q, 4'h0, pumpSpeed}
               : hitPar  ? {store_q[3], store_q[2], store_q[1], store_q[0]}
               : hitInt  ? {28'h0, stat_q}
               : hitMask ? {28'h0, mask_q} : 32'h0000_0000;
  // zero wait states: read data is caught in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access && !hit;
  assign prdata  = rdata_q;
  assign irq     = |(stat_q & mask_q);
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rdata_q <= 32'h0000_0000;
      model_q <= 1'b0;
      mask_q  <= pump_keypad_pkg::MASK_RST;
      stat_q  <= 4'h0;
    end
    else
    begin
      if (setup)
        rdata_q <= (hit && !pwrite) ? rdMux : 32'h0000_0000;
      if (wrCtrl)
        model_q <= pwdata[pump_keypad_pkg::CTRL_MODEL];
      if (wrMask)
        mask_q <= pwdata[3:0];
      // a new event beats a clear in the same cycle
      stat_q <= (stat_q & ~(wrInt ? pwdata[3:0] : 4'h0)) | evVec;
    end
  end
  // ****************************************
  // mode, screen, lock and alarm
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      mode_q   <= pump_keypad_pkg::MODE_INT;
      screen_q <= pump_keypad_pkg::SCR_RUN;
      idx_q    <= 2'h0;
      lock_q   <= 1'b0;
      alarm_q  <= 1'b0;
      combo_q  <= 1'b0;
    end
    else
    begin
      combo_q <= lvl[pump_keypad_pkg::K_DIR] & lvl[pump_keypad_pkg::K_ENT]
                 | combo_q & (lvl[pump_keypad_pkg::K_DIR] | lvl[pump_keypad_pkg::K_ENT]);
      if (comboGo)
        mode_q <= pump_keypad_pkg::MODE_INT;
      else if (modeStep)
        mode_q <= modeNx;
      if (openSet)
        screen_q <= pump_keypad_pkg::SCR_SET;
      else if (entLast)
        screen_q <= pump_keypad_pkg::SCR_RUN;
      if (openSet || entLast)
        idx_q <= 2'h0;
      else if (nextPar || entTap)
        idx_q <= idx_q + 2'h1;
      lock_q  <= lockSet | (lock_q & ~unlock);
      alarm_q <= faultEv | (alarm_q & ~clrAlarm);
    end
  end
  // ****************************************
  // motor and full speed
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      motor_q <= pump_keypad_pkg::MOTOR_RST;
      saved_q <= pump_keypad_pkg::MOTOR_RST;
      full_q  <= 1'b0;
      spd_q   <= pump_keypad_pkg::SPEED_RST;
    end
    else
    begin
      if (fullGo)
      begin
        saved_q <= motor_q;
        full_q  <= 1'b1;
      end
      else if (fullEnd)
      begin
        motor_q <= saved_q;
        full_q  <= 1'b0;
      end
      else if (dirTap)
        motor_q.dir <= ~motor_q.dir;
      else if (runTap)
        motor_q.run <= ~motor_q.run;
      if (spdInc)
        spd_q <= spdUp;
      else if (spdDec)
        spd_q <= spdDn;
    end
  end
  // ****************************************
  // parameter edit and store
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      edit_q  <= '{default: pump_keypad_pkg::PAR_RST};
      store_q <= '{default: pump_keypad_pkg::PAR_RST};
    end
    else
    begin
      if (openSet)
        edit_q <= store_q;
      else if (editInc)
        edit_q[idx_q] <= edit_q[idx_q] + 8'h01;
      else if (editDec)
        edit_q[idx_q] <= edit_q[idx_q] - 8'h01;
      if (entLast)
        store_q <= edit_q;
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pumpRun   <= 1'b0;
      pumpDir   <= 1'b0;
      pumpSpeed <= pump_keypad_pkg::SPEED_RST;
      fullInd   <= 1'b0;
    end
    else
    begin
      pumpRun   <= running;
      pumpDir   <= motor_q.dir;
      pumpSpeed <= full_q ? maxV : spd_q;
      fullInd   <= full_q;
    end
  end
  assign ctrlMode  = mode_q;
  assign setScreen = setScr;
  assign paramIdx  = idx_q;
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  dir_toggle_a: assert property (dirTap |=> motor_q.dir != $past(motor_q.dir))
    else $error("direction tap did not reverse");
  dir_block_a: assert property (
    tapG[pump_keypad_pkg::K_DIR] && !inInt && !fullEnd |=> $stable(motor_q.dir))
    else $error("direction changed outside keypad mode");
  enter_next_a: assert property (
    entTap && !entLast |=> idx_q == $past(idx_q) + 2'h1 && setScr)
    else $error("enter did not advance parameter");
  enter_save_a: assert property (
    entLast |=> runScr && store_q[$past(idx_q)] == $past(edit_q[idx_q]))
    else $error("last enter did not store and return");
  full_speed_a: assert property (
    fullGo |=> full_q ##1 pumpSpeed == $past(maxV) && fullInd && pumpRun)
    else $error("full speed not driven");
  full_restore_a: assert property (fullEnd |=> !full_q && motor_q == $past(saved_q))
    else $error("state not restored after full speed");
  speed_block_a: assert property (
    (tapG[pump_keypad_pkg::K_PLUS] || tapG[pump_keypad_pkg::K_MINUS]) && runScr
      && !inInt && !inExt |=> $stable(spd_q))
    else $error("speed changed in external mode");
  run_toggle_a: assert property (runTap |=> motor_q.run != $past(motor_q.run))
    else $error("start/stop tap ignored");
  run_block_a: assert property (
    tapG[pump_keypad_pkg::K_RUN] && !inInt && !fullEnd |=> $stable(motor_q.run))
    else $error("start/stop acted outside keypad mode");
  func_running_a: assert property (
    running && (longEv[pump_keypad_pkg::K_FUNC] || tapG[pump_keypad_pkg::K_FUNC])
      && !comboGo |=> $stable(mode_q) && $stable(screen_q) && $stable(lock_q))
    else $error("function key acted while running");
  combo_mode_a: assert property (comboGo |=> inInt ##1 inInt)
    else $error("reset combination did not select keypad mode");
  mode_cycle_a: assert property (
    modeStep && !comboGo |=> mode_q == ($past(mode_q) == 3'h6 ? 3'h0 : $past(mode_q) + 3'h1))
    else $error("mode did not advance");
endmodule // pump_keypad_handler

//--- testbench/pump_operator.sv
// operator model pressing the front-panel keys, with contact bounce
// assumes the handler samples keys on the rising edge of mclk
module pump_operator (
  // clock and keys
  input  wire logic       mclk,
  output logic      [6:0] keyRaw
);
  timeunit 1ns;
  timeprecision 1ns;
  initial keyRaw = 7'h00;
  // a real contact chatters twice before it settles
  task automatic hold(input logic [6:0] m);
    repeat (2)
    begin
      keyRaw <= keyRaw ^ m;
      @(posedge mclk);
    end
    keyRaw <= keyRaw | m;
    @(posedge mclk);
  endtask
  task automatic let_go(input logic [6:0] m);
    keyRaw <= keyRaw & ~m;
    repeat (20) @(posedge mclk);
  endtask
  task automatic press(input logic [6:0] m, input int cyc);
    hold(m);
    repeat (cyc) @(posedge mclk);
    let_go(m);
  endtask
endmodule // pump_operator

//--- testbench/test_pump_keypad_handler.sv
// self-checking bench of the pump keypad handler
// assumes shortened counts: debounce 4, long press 40, repeat 8
module test_pump_keypad_handler;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // signals
  // ****************************************
  localparam logic [6:0] DIR = 7'h01, ENT = 7'h02, PLS = 7'h04, MIN = 7'h08;
  localparam logic [6:0] RUN = 7'h10, FUN = 7'h20, FLT = 7'h40;
  // tap stays well under the long-press count
  localparam int         TAP = 12, LNG = 60;
  logic                    mclk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic                    pumpRun, pumpDir, fullInd, setScreen, irq, lastErr;
  logic [31:0]             pwdata, prdata, rd;
  logic [6:0]              keyRaw;
  pump_keypad_pkg::addr_t  paddr;
  pump_keypad_pkg::speed_t pumpSpeed;
  pump_keypad_pkg::mode_t  ctrlMode;
  pump_keypad_pkg::pidx_t  paramIdx;
  int                      fails, checks_done;

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  pump_keypad_handler #(.DEBOUNCE(4), .LONG(40), .REPEAT(8)) pump_keypad_handler_i (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .keyRaw(keyRaw), .pumpRun(pumpRun), .pumpDir(pumpDir), .pumpSpeed(pumpSpeed),
    .fullInd(fullInd), .ctrlMode(ctrlMode), .setScreen(setScreen), .paramIdx(paramIdx),
    .irq(irq)
  );
  pump_operator op_i (.mclk(mclk), .keyRaw(keyRaw));

  // ****************************************
  // helpers
  // ****************************************
  task automatic complete_run();
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkb(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  // master waits for pready, bounded so a dead slave ends the run
  task automatic apb(input logic w, input pump_keypad_pkg::addr_t a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    // one idle edge: no double drive of psel, and write results settle before checks
    @(posedge mclk);
    if (n >= 50)
    begin
      fails++;
      complete_run();
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_keypad();
    op_i.press(RUN, TAP);
    chkb("pumpRun", 1'b1, pumpRun);
    op_i.press(RUN, TAP);
    chkb("pumpRun", 1'b0, pumpRun);
    op_i.press(DIR, TAP);
    chkb("pumpDir", 1'b1, pumpDir);
    op_i.press(PLS, TAP);
    op_i.press(PLS, TAP);
    op_i.press(MIN, TAP);
    apb(1'b0, pump_keypad_pkg::OFF_SPEED, 32'h0);
    chk("setSpeed", 32'(pump_keypad_pkg::STEP_LO), 32'(rd[27:16]));
    apb(1'b1, pump_keypad_pkg::OFF_INTMASK, 32'h8);
    op_i.hold(ENT);
    repeat (LNG) @(posedge mclk);
    chkb("fullInd", 1'b1, fullInd);
    chkb("pumpRun", 1'b1, pumpRun);
    chk("pumpSpeed", 32'(pump_keypad_pkg::MAX_LO), 32'(pumpSpeed));
    chkb("irq", 1'b1, irq);
    op_i.let_go(ENT);
    chkb("fullInd", 1'b0, fullInd);
    chkb("pumpRun", 1'b0, pumpRun);
    chkb("pumpDir", 1'b1, pumpDir);
    apb(1'b1, pump_keypad_pkg::OFF_INTSTAT, 32'h8);
    chkb("irq", 1'b0, irq);
  endtask
  task automatic t_modes();
    for (int i = 1; i <= 9; i++)
    begin
      op_i.press(FUN, TAP);
      chk("ctrlMode", 32'(i % 7), 32'(ctrlMode));
      if (i == 8)
      begin
        op_i.press(RUN, TAP);
        chkb("pumpRun", 1'b0, pumpRun);
      end
    end
    op_i.press(DIR, TAP);
    chkb("pumpDir", 1'b1, pumpDir);
    op_i.press(PLS, TAP);
    apb(1'b0, pump_keypad_pkg::OFF_SPEED, 32'h0);
    chk("setSpeed", 32'(pump_keypad_pkg::STEP_LO), 32'(rd[27:16]));
    op_i.press(DIR | ENT, LNG);
    chk("ctrlMode", 32'(pump_keypad_pkg::MODE_INT), 32'(ctrlMode));
  endtask
  task automatic t_setting();
    op_i.press(FUN, LNG);
    chkb("setScreen", 1'b1, setScreen);
    chk("paramIdx", 32'h0, 32'(paramIdx));
    op_i.press(PLS, TAP);
    // held past the long-press count: two repeats before release
    op_i.press(PLS, LNG);
    op_i.press(ENT, TAP);
    chk("paramIdx", 32'h1, 32'(paramIdx));
    op_i.press(FUN, LNG);
    chk("paramIdx", 32'h2, 32'(paramIdx));
    op_i.press(ENT, TAP);
    op_i.press(ENT, TAP);
    chkb("setScreen", 1'b0, setScreen);
    apb(1'b0, pump_keypad_pkg::OFF_PARAMS, 32'h0);
    chk("params", 32'h3, rd);
  endtask
  task automatic t_guards();
    op_i.press(RUN, TAP);
    op_i.press(FUN, TAP);
    chk("ctrlMode", 32'(pump_keypad_pkg::MODE_INT), 32'(ctrlMode));
    op_i.press(FUN, LNG);
    chkb("setScreen", 1'b0, setScreen);
    op_i.press(RUN, TAP);
    apb(1'b1, pump_keypad_pkg::OFF_CTRL, 32'h2);
    op_i.press(RUN, TAP);
    chkb("pumpRun", 1'b0, pumpRun);
    op_i.press(FUN, LNG);
    apb(1'b0, pump_keypad_pkg::OFF_STATUS, 32'h0);
    chkb("lock", 1'b0, rd[pump_keypad_pkg::ST_LOCK]);
    op_i.press(FLT, TAP);
    apb(1'b0, pump_keypad_pkg::OFF_STATUS, 32'h0);
    chkb("alarm", 1'b1, rd[pump_keypad_pkg::ST_ALARM]);
    op_i.press(FUN, LNG);
    apb(1'b0, pump_keypad_pkg::OFF_STATUS, 32'h0);
    chkb("alarm", 1'b0, rd[pump_keypad_pkg::ST_ALARM]);
    chkb("setScreen", 1'b0, setScreen);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {psel, penable, pwrite, pwdata, paddr, sys_rst} = {35'h0, 8'h00, 1'b1};
    fails = 0;
    checks_done = 0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    chk("ctrlMode", 32'(pump_keypad_pkg::MODE_INT), 32'(ctrlMode));
    apb(1'b0, pump_keypad_pkg::OFF_INTMASK, 32'h0);
    chk("intMask", 32'(pump_keypad_pkg::MASK_RST), rd);
    apb(1'b0, 8'h18, 32'h0);
    chkb("pslverr", 1'b1, lastErr);
    t_keypad();
    t_modes();
    t_setting();
    t_guards();
    complete_run();
  end
endmodule // test_pump_keypad_handler
